//--- verilog/ppi_regs.vh
// Register offsets, field positions, reset values and timing counts of the printer input port
`ifndef PPI_REGS_VH
`define PPI_REGS_VH
`define PPI_CLK_HZ 50000000
`define PPI_ACK_NS 5000
`define PPI_ACK_CYC ((`PPI_ACK_NS * (`PPI_CLK_HZ / 1000000)) / 1000)
`define PPI_INIT_MIN_NS 50000
`define PPI_STB_MIN_NS 500
`define PPI_FIFO_DEPTH 32
`define PPI_DATA_W 8
`define PPI_ADDR_CTRL 12'h000
`define PPI_ADDR_STAT 12'h004
`define PPI_ADDR_DATA 12'h008
`define PPI_ADDR_CNT 12'h00C
`define PPI_CTRL_ONLINE 0
`define PPI_CTRL_NOMEDIA 1
`define PPI_CTRL_ERROR 2
`define PPI_CTRL_PRINTING 3
`define PPI_CTRL_AUTOLF 4
`define PPI_CTRL_ENTRY 5
`define PPI_CTRL_RESET 32'h0000_0001
`define PPI_STAT_EMPTY 0
`define PPI_STAT_FULL 1
`define PPI_STAT_BUSY 2
`define PPI_STAT_LINEADV 3
`define PPI_STAT_INITSEEN 4
`define PPI_DATA_VALID 8
`endif

//--- verilog/ppi_fifo.v
// Synchronous FIFO carrying received bytes to the print controller
`timescale 1ns/1ps
module ppi_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire ref_clk,
   input wire rstn,
   input wire clkEn,
   input wire flush,
   input wire [WIDTH-1:0] inData,
   input wire inValid,
   output wire inReady,
   output wire [WIDTH-1:0] outData,
   output wire outValid,
   input wire outReady,
   output wire [AW:0] level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wrPtr_r;
   reg [AW:0] rdPtr_r;
   wire full;
   wire empty;
   wire push;
   wire pop;
   assign level = wrPtr_r - rdPtr_r;
   assign full = (level == DEPTH);
   assign empty = (wrPtr_r == rdPtr_r);
   assign inReady = ~full;
   assign outValid = ~empty;
   assign push = inValid & ~full;
   assign pop = outReady & ~empty;
   assign outData = mem[rdPtr_r[AW-1:0]];
   always @(posedge ref_clk) begin
      if (clkEn && push) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr_r <= {(AW+1){1'b0}};
         rdPtr_r <= {(AW+1){1'b0}};
      end else if (clkEn) begin
         if (flush) begin
            wrPtr_r <= {(AW+1){1'b0}};
            rdPtr_r <= {(AW+1){1'b0}};
         end else begin
            if (push) begin
               wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
               rdPtr_r <= rdPtr_r + 1'b1;
            end
         end
      end
   end
endmodule

//--- verilog/ppi_apb.v
// APB slave holding the control word and reading back port state and received bytes
`timescale 1ns/1ps
`include "ppi_regs.vh"
module ppi_apb (
   input wire ref_clk,
   input wire rstn,
   input wire clkEn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] ctrl_r,
   input wire [7:0] statBits,
   input wire [7:0] fifoData,
   input wire fifoValid,
   input wire [5:0] fifoLevel,
   output wire fifoPop
);
   wire access;
   wire mapped;
   assign access = psel & penable & clkEn;
   assign pready = 1'b1;
   assign mapped = (paddr == `PPI_ADDR_CTRL) || (paddr == `PPI_ADDR_STAT) ||
      (paddr == `PPI_ADDR_DATA) || (paddr == `PPI_ADDR_CNT);
   assign pslverr = psel & penable & ~mapped;
   // Reading the data word consumes one byte, mirroring a printer pulling its buffer
   assign fifoPop = access & ~pwrite & (paddr == `PPI_ADDR_DATA) & fifoValid;
   always @* begin
      case (paddr)
         `PPI_ADDR_CTRL: prdata = ctrl_r;
         `PPI_ADDR_STAT: prdata = {24'h00_0000, statBits};
         `PPI_ADDR_DATA: prdata = {23'h00_0000, fifoValid, fifoData};
         `PPI_ADDR_CNT: prdata = {26'h000_0000, fifoLevel};
         default: prdata = 32'h0000_0000;
      endcase
   end
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `PPI_CTRL_RESET;
      end else if (access && pwrite && paddr == `PPI_ADDR_CTRL) begin
         ctrl_r <= pwdata;
      end
   end
endmodule

//--- verilog/ppi_port.v
// Printer side of the strobed 8-bit parallel input port
// Function
// - Strobe idles high, byte captured while low
// - Eight data lines, high means one
// - Emit about 5 us accepted pulse
// - Busy high during entry, printing, offline, error
// - No-media output high when paper out
// - Selected output shows printer selected
// - Line-advance low feeds line after printing
// - Host reset low clears controller and buffer; code flushes buffer and resets handshake, leaves control word
// - Error output low on paper-out, offline, error
// - Accept data only while entry enable low; code also accepts with entryEnableInN high while entryStrap is high
`timescale 1ns/1ps
`include "ppi_regs.vh"
module ppi_port #(
   parameter DATA_W = `PPI_DATA_W,
   parameter FIFO_DEPTH = `PPI_FIFO_DEPTH,
   parameter ACK_CYC = `PPI_ACK_CYC
) (
   input wire ref_clk,
   input wire rstn,
   input wire clkEn,
   input wire strobeN,
   input wire [DATA_W-1:0] dataIn,
   input wire initN,
   input wire lineAdvanceReqN,
   input wire entryEnableInN,
   input wire autoLfStrap,
   input wire entryStrap,
   output reg byteAcceptedPulseN,
   output wire busy,
   output wire noMediaFlag,
   output wire onlineSelected,
   output wire errorN,
   output wire lineAdvance,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr
);
   // ==========================================
   // States of the receive handshake
   localparam ST_IDLE = 2'd0;
   localparam ST_LOW = 2'd1;
   localparam ST_PUSH = 2'd2;
   localparam ST_ACK = 2'd3;
   localparam [15:0] CNT_ZERO = 16'h0000;
   localparam [15:0] CNT_ONE = 16'h0001;

   // ==========================================
   // Helpers
   // Falling level between two samples of an idle-high host line
   function fall_edge;
      input prev;
      input now;
      begin
         fall_edge = prev & ~now;
      end
   endfunction

   // A new byte is taken only from idle, so a strobe during the pulse is ignored
   function strobe_taken;
      input [1:0] st;
      input fall;
      input ok;
      input on;
      begin
         strobe_taken = (st == ST_IDLE) && fall && ok && on;
      end
   endfunction

   function ack_done;
      input [1:0] st;
      input [15:0] cnt;
      begin
         ack_done = (st == ST_ACK) && (cnt == CNT_ZERO);
      end
   endfunction

   // ==========================================
   // Internal signals
   // Registered state and its next values
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [DATA_W-1:0] byte_r;
   reg [DATA_W-1:0] byte_nxt;
   reg [15:0] ackCnt_r;
   reg [15:0] ackCnt_nxt;
   reg ackPulse_nxt;
   reg strobePrev_r;
   reg initPrev_r;
   reg initSeen_r;
   reg initSeen_nxt;

   // Nets
   wire [31:0] ctrl;
   wire [31:0] ackLoadFull;
   wire [15:0] ackLoad;
   wire fifoInReady;
   wire fifoOutValid;
   wire [DATA_W-1:0] fifoOutData;
   wire [5:0] fifoLevel;
   wire fifoPop;
   wire fifoPush;
   wire online;
   wire printErr;
   wire printing;
   wire entryOk;
   wire hostInit;
   wire strobeFall;
   wire initFall;
   wire statRead;
   wire portBusy;
   wire busyPrinting;
   wire busyFull;
   wire busyOffline;
   wire busyError;
   wire busyInit;
   wire [7:0] statBits;

   // ==========================================
   // Pulse length kept in the counter width; settings above 65536 cycles would wrap
   assign ackLoadFull = ACK_CYC - 1;
   assign ackLoad = ackLoadFull[15:0];

   // ==========================================
   // Controller state from software
   assign online = ctrl[`PPI_CTRL_ONLINE];
   assign printErr = ctrl[`PPI_CTRL_ERROR];
   assign printing = ctrl[`PPI_CTRL_PRINTING];
   assign noMediaFlag = ctrl[`PPI_CTRL_NOMEDIA];
   assign onlineSelected = online;
   assign errorN = ~(noMediaFlag | ~online | printErr);

   // ==========================================
   // Host pins
   assign hostInit = ~initN;
   assign strobeFall = fall_edge(strobePrev_r, strobeN);
   assign initFall = fall_edge(initPrev_r, initN);
   // Straps act like the internal switches that tie the inputs low
   assign entryOk = ~entryEnableInN | entryStrap;
   assign lineAdvance = ~lineAdvanceReqN | autoLfStrap | ctrl[`PPI_CTRL_AUTOLF];
   assign statRead = psel & penable & ~pwrite & (paddr == `PPI_ADDR_STAT);

   // History resets to the idle level, so no false edge follows reset
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         strobePrev_r <= 1'b1;
         initPrev_r <= 1'b1;
      end else if (clkEn) begin
         strobePrev_r <= strobeN;
         initPrev_r <= initN;
      end
   end

   // ==========================================
   // Busy sources
   assign portBusy = (state_r != ST_IDLE) | ~strobeN;
   assign busyPrinting = printing;
   // Buffer full counts as printing: the controller cannot take data
   assign busyFull = ~fifoInReady;
   assign busyOffline = ~online;
   assign busyError = printErr | noMediaFlag;
   assign busyInit = hostInit;
   assign busy = portBusy | busyPrinting | busyFull | busyOffline | busyError
      | busyInit;

   // ==========================================
   // Handshake sequencing
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (strobe_taken(state_r, strobeFall, entryOk, online)) begin
               state_nxt = ST_LOW;
            end
         end
         ST_LOW: begin
            if (strobeN) begin
               state_nxt = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (fifoInReady) begin
               state_nxt = ST_ACK;
            end
         end
         ST_ACK: begin
            if (ack_done(state_r, ackCnt_r)) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
      end else if (clkEn) begin
         if (hostInit) begin
            state_r <= ST_IDLE;
         end else begin
            state_r <= state_nxt;
         end
      end
   end

   // ==========================================
   // Byte latch follows the lines only while the strobe is low
   always @* begin
      byte_nxt = byte_r;
      if (strobe_taken(state_r, strobeFall, entryOk, online)) begin
         byte_nxt = dataIn;
      end else if (state_r == ST_LOW && !strobeN) begin
         byte_nxt = dataIn;
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         byte_r <= {DATA_W{1'b0}};
      end else if (clkEn && !hostInit) begin
         byte_r <= byte_nxt;
      end
   end

   // ==========================================
   // Accepted pulse timing
   assign fifoPush = (state_r == ST_PUSH) & fifoInReady;

   always @* begin
      ackCnt_nxt = ackCnt_r;
      ackPulse_nxt = byteAcceptedPulseN;
      if (fifoPush) begin
         ackPulse_nxt = 1'b0;
         ackCnt_nxt = ackLoad;
      end else if (ack_done(state_r, ackCnt_r)) begin
         ackPulse_nxt = 1'b1;
      end else if (state_r == ST_ACK) begin
         ackCnt_nxt = ackCnt_r - CNT_ONE;
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ackCnt_r <= CNT_ZERO;
         byteAcceptedPulseN <= 1'b1;
      end else if (clkEn) begin
         if (hostInit) begin
            ackCnt_r <= CNT_ZERO;
            byteAcceptedPulseN <= 1'b1;
         end else begin
            ackCnt_r <= ackCnt_nxt;
            byteAcceptedPulseN <= ackPulse_nxt;
         end
      end
   end

   // ==========================================
   // Host reset marker, cleared by a status read; a new reset in that cycle wins
   always @* begin
      initSeen_nxt = initSeen_r;
      if (statRead) begin
         initSeen_nxt = 1'b0;
      end
      if (initFall) begin
         initSeen_nxt = 1'b1;
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         initSeen_r <= 1'b0;
      end else if (clkEn) begin
         initSeen_r <= initSeen_nxt;
      end
   end

   // ==========================================
   // Status word
   assign statBits[`PPI_STAT_EMPTY] = ~fifoOutValid;
   assign statBits[`PPI_STAT_FULL] = ~fifoInReady;
   assign statBits[`PPI_STAT_BUSY] = busy;
   assign statBits[`PPI_STAT_LINEADV] = lineAdvance;
   assign statBits[`PPI_STAT_INITSEEN] = initSeen_r;
   assign statBits[7:5] = 3'b000;

   // ==========================================
   // Byte buffer and register access
   ppi_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH),
      .AW(5)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .flush(hostInit),
      .inData(byte_r),
      .inValid(state_r == ST_PUSH),
      .inReady(fifoInReady),
      .outData(fifoOutData),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .level(fifoLevel)
   );

   ppi_apb u_apb (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ctrl_r(ctrl),
      .statBits(statBits),
      .fifoData(fifoOutData),
      .fifoValid(fifoOutValid),
      .fifoLevel(fifoLevel),
      .fifoPop(fifoPop)
   );
endmodule

//--- dv/ppi_port_monitor.sv
// Checker bound to the printer input port
`timescale 1ns/1ps
module ppi_port_monitor #(
   parameter ACK_CYC = 250
) (
   input wire ref_clk,
   input wire rstn,
   input wire strobeN,
   input wire initN,
   input wire lineAdvanceReqN,
   input wire entryEnableInN,
   input wire autoLfStrap,
   input wire entryStrap,
   input wire byteAcceptedPulseN,
   input wire busy,
   input wire noMediaFlag,
   input wire onlineSelected,
   input wire errorN
   ,input wire lineAdvance
);
   // ==========
   // Pulse width counter
   reg [15:0] lowCnt_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         lowCnt_r <= 16'h0000;
      else if (byteAcceptedPulseN)
         lowCnt_r <= 16'h0000;
      else
         lowCnt_r <= lowCnt_r + 16'h0001;
   end
   // Remembers whether the last strobe fell from idle while entry was disabled
   reg strobePrev_r;
   reg busyPrev_r;
   reg gatedFall_r;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         strobePrev_r <= 1'b1;
         busyPrev_r <= 1'b0;
         gatedFall_r <= 1'b0;
      end else begin
         strobePrev_r <= strobeN;
         busyPrev_r <= busy;
         if (strobePrev_r && !strobeN) begin
            gatedFall_r <= entryEnableInN && !entryStrap && !busyPrev_r;
         end
      end
   end
   // ==========
   // Properties
   a_strobe_busy: assert property (!strobeN && !entryEnableInN |-> busy)
      else $error("busy low with strobe held");
   a_ack_busy: assert property (!byteAcceptedPulseN |-> busy)
      else $error("busy low during accept pulse");
   // An init cuts the pulse short, so that case is left out
   a_ack_width: assert property ($rose(byteAcceptedPulseN) && $past(initN) |-> lowCnt_r == ACK_CYC)
      else $error("accept pulse width wrong");
   a_nomedia_err: assert property (noMediaFlag |-> !errorN)
      else $error("error high while out of paper");
   a_offline: assert property (!onlineSelected |-> busy && !errorN)
      else $error("offline not flagged");
   a_entry_gate: assert property ($rose(strobeN) && gatedFall_r |-> byteAcceptedPulseN [*3])
      else $error("byte taken with entry disabled");
   a_auto_lf: assert property (!lineAdvanceReqN || autoLfStrap |-> lineAdvance)
      else $error("line advance not requested");
   a_init_ack: assert property (!initN |=> byteAcceptedPulseN)
      else $error("handshake not cleared by init");
   c_ack: cover property ($rose(byteAcceptedPulseN));
   c_off: cover property (!onlineSelected);
   c_init: cover property (!initN);
   c_gated: cover property ($rose(strobeN) && gatedFall_r);
endmodule
bind ppi_port ppi_port_monitor #(.ACK_CYC(ACK_CYC)) mon (
   .ref_clk(ref_clk),
   .rstn(rstn),
   .strobeN(strobeN),
   .initN(initN),
   .lineAdvanceReqN(lineAdvanceReqN),
   .entryEnableInN(entryEnableInN),
   .autoLfStrap(autoLfStrap),
   .entryStrap(entryStrap),
   .byteAcceptedPulseN(byteAcceptedPulseN),
   .busy(busy),
   .noMediaFlag(noMediaFlag),
   .onlineSelected(onlineSelected),
   .errorN(errorN),
   .lineAdvance(lineAdvance)
);

//--- dv/ppi_host_model.sv
// Host model driving strobe, data and init of the printer port
`timescale 1ns/1ps
module ppi_host_model (
   input wire ref_clk,
   input wire busy,
   output reg strobeN,
   output reg [7:0] dataIn,
   output reg initN
);
   initial begin
      strobeN = 1'b1;
      initN = 1'b1;
      dataIn = 8'h00;
   end
   // A full buffer shows up here as a long wait for busy
   task send(input [7:0] b);
      integer k;
      begin
         @(posedge ref_clk);
         while (busy !== 1'b0) @(posedge ref_clk);
         dataIn <= b;
         strobeN <= 1'b0;
         for (k = 0; k < 30; k = k + 1) @(posedge ref_clk);
         strobeN <= 1'b1;
         @(posedge ref_clk);
         // Undriven data must not keep looking valid
         dataIn <= ~b;
      end
   endtask
   task pulse_init;
      begin
         @(posedge ref_clk);
         initN <= 1'b0;
         repeat (2600) @(posedge ref_clk);
         initN <= 1'b1;
         @(posedge ref_clk);
      end
   endtask
endmodule

//--- dv/ppi_port_tb.sv
// Self-checking bench for the printer input port
`timescale 1ns/1ps
module ppi_port_tb;
   reg ref_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg lineAdvanceReqN = 1'b1, entryEnableInN = 1'b0, autoLfStrap = 1'b0, entryStrap = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000, q;
   reg qErr = 1'b0;
   wire strobeN, initN, byteAcceptedPulseN, busy, noMediaFlag, onlineSelected, errorN;
   wire lineAdvance, pready, pslverr;
   wire [7:0] dataIn;
   wire [31:0] prdata;
   integer err_total = 0, checks = 0, i;
   always #10 ref_clk = ~ref_clk;
   ppi_port dut (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .strobeN(strobeN),
      .dataIn(dataIn),
      .initN(initN),
      .lineAdvanceReqN(lineAdvanceReqN),
      .entryEnableInN(entryEnableInN),
      .autoLfStrap(autoLfStrap),
      .entryStrap(entryStrap),
      .byteAcceptedPulseN(byteAcceptedPulseN),
      .busy(busy),
      .noMediaFlag(noMediaFlag),
      .onlineSelected(onlineSelected),
      .errorN(errorN),
      .lineAdvance(lineAdvance),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );
   ppi_host_model host (.ref_clk(ref_clk), .busy(busy), .strobeN(strobeN),
      .dataIn(dataIn), .initN(initN));
   // ==========
   // Shared tasks
   task chk(input string n, input [31:0] s, input [31:0] e);
      begin
         checks = checks + 1;
         if (s !== e) begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge ref_clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge ref_clk);
         penable <= 1'b1;
         @(posedge ref_clk);
         while (pready !== 1'b1) @(posedge ref_clk);
         q = prdata;
         qErr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task lf(input [1:0] v);
      begin
         {lineAdvanceReqN, autoLfStrap} <= v;
         repeat (2) @(posedge ref_clk);
      end
   endtask
   task conclude;
      begin
         $display("Checks %0d errors %0d", checks, err_total);
         if (err_total == 0 && checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // ==========
   // Scenarios
   task t_status;
      begin
         apb(1'b1, 12'h000, 32'h0000_0000);
         chk("offline", {busy, errorN, onlineSelected}, 32'h0000_0004);
         apb(1'b1, 12'h000, 32'h0000_0003);
         chk("nomedia", {noMediaFlag, errorN, onlineSelected}, 32'h0000_0005);
         apb(1'b1, 12'h000, 32'h0000_0009);
         chk("printing", {busy, errorN}, 32'h0000_0003);
         apb(1'b1, 12'h000, 32'h0000_0005);
         chk("error", {busy, errorN}, 32'h0000_0002);
         apb(1'b1, 12'h000, 32'h0000_0001);
         chk("online", {busy, errorN}, 32'h0000_0001);
         apb(1'b0, 12'h010, 32'h0000_0000);
         chk("slverr", qErr, 32'h0000_0001);
         chk("unmapped", q, 32'h0000_0000);
         // A write while the clock enable is low must be dropped
         clkEn <= 1'b0;
         apb(1'b1, 12'h000, 32'h0000_0000);
         clkEn <= 1'b1;
         chk("frozen", {busy, onlineSelected}, 32'h0000_0001);
      end
   endtask
   task t_lf;
      begin
         lf(2'b00);
         chk("lfreq", lineAdvance, 32'h0000_0001);
         lf(2'b11);
         chk("lfstrap", lineAdvance, 32'h0000_0001);
         lf(2'b10);
         chk("lfoff", lineAdvance, 32'h0000_0000);
      end
   endtask
   task t_entry;
      begin
         entryEnableInN <= 1'b1;
         host.send(8'h11);
         repeat (300) @(posedge ref_clk);
         apb(1'b0, 12'h00C, 32'h0000_0000);
         chk("gated", q, 32'h0000_0000);
         entryStrap <= 1'b1;
         host.send(8'h22);
         repeat (300) @(posedge ref_clk);
         apb(1'b0, 12'h00C, 32'h0000_0000);
         chk("strap", q, 32'h0000_0001);
         entryStrap <= 1'b0;
         entryEnableInN <= 1'b0;
      end
   endtask
   task t_init;
      begin
         host.pulse_init;
         apb(1'b0, 12'h00C, 32'h0000_0000);
         chk("flushed", q, 32'h0000_0000);
         apb(1'b0, 12'h004, 32'h0000_0000);
         chk("initseen", q, 32'h0000_0011);
         apb(1'b0, 12'h004, 32'h0000_0000);
         chk("initclr", q, 32'h0000_0001);
      end
   endtask
   task t_fill;
      begin
         for (i = 0; i < 32; i = i + 1) host.send(i[7:0] ^ 8'hA5);
         apb(1'b0, 12'h00C, 32'h0000_0000);
         chk("full", q, 32'h0000_0020);
         // The host waits on busy while the buffer is full, so it runs alongside the reads
         fork
            host.send(8'h5A);
         join_none
         repeat (300) @(posedge ref_clk);
         chk("stall", {busy, byteAcceptedPulseN}, 32'h0000_0003);
         for (i = 0; i < 32; i = i + 1) begin
            apb(1'b0, 12'h008, 32'h0000_0000);
            chk("data", q, {23'h00_0000, 1'b1, i[7:0] ^ 8'hA5});
         end
         repeat (300) @(posedge ref_clk);
         apb(1'b0, 12'h008, 32'h0000_0000);
         chk("last", q, 32'h0000_015A);
         apb(1'b0, 12'h00C, 32'h0000_0000);
         chk("empty", q, 32'h0000_0000);
      end
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      t_status;
      t_lf;
      t_entry;
      t_init;
      t_fill;
      conclude;
   end
   initial begin
      #1_000_000;
      err_total = err_total + 1;
      conclude;
   end
endmodule
